// ### hdl/dram_host_pkg.sv
// Constants, types and timing for the page-mode DRAM host controller
package dram_host_pkg;

  // ****************************************
  // Array geometry
  // ****************************************
  localparam int ADDR_W = 24;
  localparam int ROW_W = 13;
  localparam int COL_W = 11;
  localparam int PIN_W = 13;
  localparam int DATA_W = 4;
  localparam int ROW_LSB = 11;
  localparam int FIFO_DEPTH = 8;
  localparam int WAKE_CYCLES = 8;

  // ****************************************
  // Timing in printed units
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int T_RCD_NS = 20;
  localparam int T_RAC_NS = 60;
  localparam int T_RAS_NS = 60;
  localparam int T_RP_NS = 40;
  localparam int T_CSR_NS = 5;
  localparam int T_INIT_US = 100;
  localparam int T_REF_MS = 64;
  localparam int REF_ROWS = 4096;

  // ****************************************
  // Timing in clock cycles
  // ****************************************
  typedef logic [15:0] cnt_t;
  localparam cnt_t RCD_CYC = 16'((T_RCD_NS * CLK_MHZ + 999) / 1000);
  localparam cnt_t ACC_CYC = 16'(((T_RAC_NS - T_RCD_NS) * CLK_MHZ + 999) / 1000);
  localparam cnt_t RAS_CYC = 16'((T_RAS_NS * CLK_MHZ + 999) / 1000);
  localparam cnt_t RP_CYC = 16'((T_RP_NS * CLK_MHZ + 999) / 1000);
  localparam cnt_t CSR_CYC = 16'((T_CSR_NS * CLK_MHZ + 999) / 1000);
  // Longest spacing between refreshes, rounded down
  localparam cnt_t REF_CYC = 16'((T_REF_MS * 1000 * CLK_MHZ) / REF_ROWS);
  localparam int INIT_CYC = T_INIT_US * CLK_MHZ;
  localparam cnt_t CNT_ONE = 16'h0001;
  localparam cnt_t CNT_ZERO = 16'h0000;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } req_s;
  localparam int REQ_W = $bits(req_s);

  typedef enum logic [6:0] {
    ST_INIT    = 7'h01,
    ST_IDLE    = 7'h02,
    ST_ROW     = 7'h04,
    ST_COL     = 7'h08,
    ST_PRE     = 7'h10,
    ST_CBR_CAS = 7'h20,
    ST_CBR_RAS = 7'h40
  } state_e;

  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic oe_n;
    logic [PIN_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
  } pins_s;

  typedef struct packed {
    state_e st;
    cnt_t cnt;
    cnt_t ref_cnt;
    logic ref_pend;
    logic [3:0] wake_cnt;
    logic cur_write;
    logic [COL_W-1:0] cur_col;
    pins_s pins;
    logic rd_valid;
    logic [DATA_W-1:0] rd_data;
  } ctl_s;

endpackage

// ### hdl/dram_host.sv
// Host controller driving a 16M x 4 page-mode DRAM, with request FIFO
`timescale 1ns/1ps

// ****************************************
// Request FIFO
// ****************************************
module req_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [AW:0] count_reg, count_next;
  logic push, pop, ready_reg;

  // Ready is registered so the port comes straight from a flip-flop
  assign in_ready = ready_reg;
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign out_valid = count_reg != '0;
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b1;
    end
    else
    begin
      ready_reg <= count_next != FULL_CNT;
      if (push)
      begin
        mem[wr_ptr_reg] <= in_data;
        wr_ptr_reg <= (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'b1;
      count_reg <= count_next;
    end
  end
endmodule // req_fifo

// ****************************************
// DRAM host controller
// ****************************************
module dram_host
  import dram_host_pkg::*;
#(
  parameter int INIT_WAIT = dram_host_pkg::INIT_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // User requests
  input wire logic req_valid,
  output logic req_ready,
  input wire dram_host_pkg::req_s req,
  // Read answers
  output logic rd_valid,
  output logic [dram_host_pkg::DATA_W-1:0] rd_data,
  // Status
  output logic init_done,
  // DRAM pins
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic oe_n,
  output logic [dram_host_pkg::PIN_W-1:0] mux_address_pins,
  output logic [dram_host_pkg::DATA_W-1:0] data_pins_out,
  output logic data_pins_oe,
  input wire logic [dram_host_pkg::DATA_W-1:0] data_pins_in
);
  import dram_host_pkg::*;

  localparam pins_s PINS_IDLE = '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                                  addr: '0, dq_out: '0, dq_oe: 1'b0};
  localparam logic [3:0] WAKE_N = 4'(WAKE_CYCLES);
  localparam cnt_t INIT_START = 16'(INIT_WAIT - 1);

  ctl_s c_reg, c_next;
  req_s head;
  logic head_valid, head_take, ref_tick, ref_clear, init_done_reg;

  req_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(req),
    .out_valid(head_valid),
    .out_ready(head_take),
    .out_data(head)
  );

  // Refresh and wake-up cycles win over user traffic
  assign head_take = (c_reg.st == ST_IDLE) && !c_reg.ref_pend && (c_reg.wake_cnt == '0) && head_valid;
  assign ref_tick = c_reg.ref_cnt == CNT_ZERO;
  assign ref_clear = (c_reg.st == ST_IDLE) && (c_reg.wake_cnt == '0) && c_reg.ref_pend;

  always_comb
  begin
    c_next = c_reg;
    c_next.rd_valid = 1'b0;
    c_next.ref_cnt = ref_tick ? REF_CYC - CNT_ONE : c_reg.ref_cnt - CNT_ONE;
    // A tick in the clearing cycle keeps the request pending
    c_next.ref_pend = (c_reg.ref_pend && !ref_clear) || (ref_tick && c_reg.st != ST_INIT);
    if (c_reg.cnt != CNT_ZERO)
      c_next.cnt = c_reg.cnt - CNT_ONE;
    unique case (c_reg.st)
      ST_INIT:
      begin
        if (c_reg.cnt == CNT_ZERO)
        begin
          c_next.st = ST_IDLE;
          c_next.wake_cnt = WAKE_N;
        end
      end
      ST_IDLE:
      begin
        if (c_reg.wake_cnt != '0 || c_reg.ref_pend)
        begin
          // Column strobe first, write enable high: a plain refresh, not test mode
          c_next.st = ST_CBR_CAS;
          c_next.pins.cas_n = 1'b0;
          c_next.pins.we_n = 1'b1;
          c_next.cnt = CSR_CYC - CNT_ONE;
          if (c_reg.wake_cnt != '0)
            c_next.wake_cnt = c_reg.wake_cnt - 4'h1;
        end
        else if (head_valid)
        begin
          c_next.st = ST_ROW;
          c_next.cur_write = head.write;
          c_next.cur_col = head.addr[COL_W-1:0];
          c_next.pins.ras_n = 1'b0;
          c_next.pins.addr = head.addr[ADDR_W-1:ROW_LSB];
          // Write enable falls ahead of the column strobe: early write only
          c_next.pins.we_n = !head.write;
          c_next.pins.dq_out = head.data;
          c_next.pins.dq_oe = head.write;
          c_next.cnt = RCD_CYC - CNT_ONE;
        end
      end
      ST_ROW:
      begin
        if (c_reg.cnt == CNT_ZERO)
        begin
          c_next.st = ST_COL;
          c_next.pins.addr = {{(PIN_W-COL_W){1'b0}}, c_reg.cur_col};
          c_next.pins.cas_n = 1'b0;
          c_next.pins.oe_n = c_reg.cur_write;
          c_next.cnt = ACC_CYC - CNT_ONE;
        end
      end
      ST_COL:
      begin
        if (c_reg.cnt == CNT_ZERO)
        begin
          c_next.st = ST_PRE;
          c_next.rd_valid = !c_reg.cur_write;
          if (!c_reg.cur_write)
            c_next.rd_data = data_pins_in;
          // Both strobes rise together; row closes after one column
          c_next.pins = PINS_IDLE;
          c_next.cnt = RP_CYC - CNT_ONE;
        end
      end
      ST_CBR_CAS:
      begin
        if (c_reg.cnt == CNT_ZERO)
        begin
          c_next.st = ST_CBR_RAS;
          c_next.pins.ras_n = 1'b0;
          c_next.cnt = RAS_CYC - CNT_ONE;
        end
      end
      ST_CBR_RAS:
      begin
        // Row strobe low only RAS_CYC here, never near self-refresh entry
        if (c_reg.cnt == CNT_ZERO)
        begin
          c_next.st = ST_PRE;
          c_next.pins = PINS_IDLE;
          c_next.cnt = RP_CYC - CNT_ONE;
        end
      end
      ST_PRE:
      begin
        // Column strobe high through precharge clears the device output buffer
        if (c_reg.cnt == CNT_ZERO)
          c_next.st = ST_IDLE;
      end
      default:
        c_next.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      c_reg.st <= ST_INIT;
      c_reg.cnt <= INIT_START;
      c_reg.ref_cnt <= REF_CYC - CNT_ONE;
      c_reg.ref_pend <= 1'b0;
      c_reg.wake_cnt <= '0;
      c_reg.cur_write <= 1'b0;
      c_reg.cur_col <= '0;
      c_reg.pins <= PINS_IDLE;
      c_reg.rd_valid <= 1'b0;
      c_reg.rd_data <= '0;
      init_done_reg <= 1'b0;
    end
    else
    begin
      c_reg <= c_next;
      if (c_reg.st == ST_IDLE && c_reg.wake_cnt == '0)
        init_done_reg <= 1'b1;
    end
  end

  assign ras_n = c_reg.pins.ras_n;
  assign cas_n = c_reg.pins.cas_n;
  assign we_n = c_reg.pins.we_n;
  assign oe_n = c_reg.pins.oe_n;
  assign mux_address_pins = c_reg.pins.addr;
  assign data_pins_out = c_reg.pins.dq_out;
  assign data_pins_oe = c_reg.pins.dq_oe;
  assign rd_valid = c_reg.rd_valid;
  assign rd_data = c_reg.rd_data;
  assign init_done = init_done_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  cnt_t gap_reg;
  logic seen_ref_reg;
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      gap_reg <= '0;
      seen_ref_reg <= 1'b0;
    end
    else if (!c_reg.pins.cas_n && $fell(c_reg.pins.ras_n))
    begin
      gap_reg <= '0;
      seen_ref_reg <= 1'b1;
    end
    else if (gap_reg != 16'hFFFF)
      gap_reg <= gap_reg + CNT_ONE;
  end

  AST_READ_WE_HIGH: assert property ((c_reg.st == ST_COL && !c_reg.cur_write) |-> we_n ##1 we_n)
    else $error("write enable low during read");
  AST_EARLY_WRITE: assert property (($fell(cas_n) && !ras_n && c_reg.cur_write) |-> $past(!we_n))
    else $error("write enable not low before column strobe");
  AST_DATA_HOLD: assert property (($fell(cas_n) && !we_n) |-> (data_pins_oe && $stable(data_pins_out))[*3])
    else $error("write data not held around column strobe");
  AST_CBR_WE: assert property (($fell(cas_n) && ras_n) |-> we_n[*2] ##1 (we_n && !ras_n))
    else $error("write enable low in refresh setup");
  AST_CAS_BEFORE_RAS: assert property ($fell(ras_n) |-> $past(cas_n, 2))
    else $error("column strobe not pulsed high before row strobe");
  AST_RAS_WIDTH: assert property ($fell(ras_n) |-> (!ras_n)[*6] ##1 ras_n)
    else $error("row strobe width wrong");
  AST_PRECHARGE: assert property ($rose(ras_n) |-> ras_n[*4])
    else $error("row precharge too short");
  AST_REFRESH_GAP: assert property ((seen_ref_reg && init_done) |-> gap_reg <= REF_CYC + 16'h0040)
    else $error("refresh interval exceeded");
  AST_OE_ONLY_READ: assert property (!oe_n |-> (!cas_n && we_n))
    else $error("output enable outside a read");
  AST_WAKE: assert property ($rose(init_done) |-> $past(c_reg.wake_cnt == '0))
    else $error("ready before wake-up refreshes");

  COV_READ: cover property (rd_valid);
  COV_WRITE: cover property ($fell(cas_n) && !we_n);
  COV_REFRESH: cover property ($fell(ras_n) && !cas_n && init_done);
  COV_FULL: cover property (req_valid && !req_ready);
endmodule // dram_host

// ### verification/dram_device_model.sv
// Behavioural page-mode DRAM device seen from the host's pins
`timescale 1ns/1ps

module dram_device_model
  import dram_host_pkg::*;
(
  // Strobes
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic oe_n,
  // Address and data
  input wire logic [dram_host_pkg::PIN_W-1:0] mux_address_pins,
  input wire logic [dram_host_pkg::DATA_W-1:0] data_wire,
  output logic [dram_host_pkg::DATA_W-1:0] dq_drive,
  output logic dq_en,
  // Observation
  output int refresh_count,
  output int fault_count
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [ROW_W-1:0] row_reg;
  logic [ADDR_W-1:0] loc;
  logic [11:0] ref_row;
  logic [DATA_W-1:0] word;
  logic [DATA_W-1:0] last;
  logic reading;
  realtime ras_fall_t;

  initial
  begin
    refresh_count = 0;
    fault_count = 0;
    ref_row = 12'h000;
    reading = 1'b0;
    word = 4'h0;
    last = 4'h0;
    ras_fall_t = 0.0;
  end

  // Self refresh would need an exit burst this bench never models
  always @(posedge ras_n)
    if (cas_n === 1'b0 && ($realtime - ras_fall_t) >= 100000.0)
      fault_count++;

  // ****************************************
  // Row strobe: access or refresh
  // ****************************************
  always @(negedge ras_n)
  begin
    // Let the address pins settle; they change in the same step as the strobe
    #1;
    ras_fall_t = $realtime;
    if (cas_n === 1'b0)
    begin
      // Output stays as it was; counter picks the rows
      refresh_count++;
      ref_row++;
      if (we_n !== 1'b1)
        fault_count++;
    end
    else
      row_reg = mux_address_pins[ROW_W-1:0];
  end

  // ****************************************
  // Column strobe: each fall is a new column
  // ****************************************
  always @(negedge cas_n)
  begin
    #1;
    if (ras_n === 1'b0)
    begin
      loc = {row_reg, mux_address_pins[COL_W-1:0]};
      reading = (we_n === 1'b1);
      if (we_n === 1'b0)
        mem[loc] = data_wire;
      word = mem.exists(loc) ? mem[loc] : ~last;
    end
  end

  // Write enable falling inside a read would be late write or read-modify-write
  always @(negedge we_n)
    if (cas_n === 1'b0 && reading)
      fault_count++;

  always @(posedge cas_n)
  begin
    last = word;
    reading = 1'b0;
  end

  // Released pins show the inverse, never a stale match
  always @*
  begin
    dq_en = reading && (cas_n === 1'b0) && (oe_n === 1'b0);
    dq_drive = dq_en ? word : ~last;
  end
endmodule
// dram_device_model

// ### verification/dram_host_tb.sv
// Self-checking bench for the DRAM host controller
`timescale 1ns/1ps

module dram_host_tb;
  import dram_host_pkg::*;
  typedef struct {logic [ADDR_W-1:0] addr; logic [DATA_W-1:0] data;} row_s;
  localparam int INIT_SIM = 20;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  req_s req = '0;
  logic req_ready, rd_valid, init_done, ras_n, cas_n, we_n, oe_n, data_pins_oe, dq_en;
  logic [DATA_W-1:0] rd_data, data_pins_out, dq_drive, data_wire;
  logic [PIN_W-1:0] mux_address_pins;
  int refresh_count, fault_count, rc, i;
  int failures = 0;
  int checks = 0;
  int clash = 0;
  logic [DATA_W-1:0] got [$];
  // Row and column boundaries, so a swapped or shifted field aliases
  row_s rows [8] = '{'{24'h000000, 4'h5}, '{24'hFFFFFF, 4'hA}, '{24'h0007FF, 4'h3}, '{24'h000800, 4'hC},
                     '{24'hFFF800, 4'h9}, '{24'h0007FE, 4'h6}, '{24'h123456, 4'hF}, '{24'h800001, 4'h0}};

  always #5 sys_clk = ~sys_clk;
  assign data_wire = data_pins_oe ? data_pins_out : dq_drive;

  always @(negedge sys_clk)
  begin
    if (rd_valid === 1'b1)
      got.push_back(rd_data);
    if (data_pins_oe === 1'b1 && dq_en === 1'b1)
      clash++;
  end

  dram_host #(.INIT_WAIT(INIT_SIM)) dut (.sys_clk(sys_clk), .reset(reset), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rd_valid(rd_valid), .rd_data(rd_data), .init_done(init_done),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n), .mux_address_pins(mux_address_pins),
    .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe), .data_pins_in(data_wire));

  dram_device_model dev (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n),
    .mux_address_pins(mux_address_pins), .data_wire(data_wire), .dq_drive(dq_drive), .dq_en(dq_en),
    .refresh_count(refresh_count), .fault_count(fault_count));

  // ****************************************
  // Compare and control tasks
  // ****************************************
  task automatic check_data(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] seen);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic check_bit(input string name, input logic exp, input logic seen);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %b seen %b", name, exp, seen);
    end
  endtask

  task automatic check_cnt(input string name, input int exp, input int seen);
    checks++;
    if (seen != exp)
    begin
      failures++;
      $display("[ERR] %s expected %0d seen %0d", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic timed_out(input string name);
    failures++;
    $display("[ERR] %s expected done seen timeout", name);
    print_verdict();
  endtask

  // Called at a falling edge; valid stays up for the caller to drop
  task automatic send(input logic wr, input row_s r);
    int k;
    req_valid = 1'b1;
    req = '{write: wr, addr: r.addr, data: r.data};
    for (k = 0; k < 3000 && req_ready !== 1'b1; k++)
      @(negedge sys_clk);
    if (k == 3000)
      timed_out("request accept");
    @(negedge sys_clk);
  endtask

  task automatic wait_reads(input int n);
    int k;
    for (k = 0; k < 3000 && got.size() < n; k++)
      @(negedge sys_clk);
    if (got.size() < n)
      timed_out("read answers");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (2) @(negedge sys_clk);
    check_bit("ras_n in reset", 1'b1, ras_n);
    check_bit("rd_valid in reset", 1'b0, rd_valid);
    reset = 1'b0;
    // Fill the queue during the power-up wait, before the wake-up refreshes start
    for (i = 0; i < 8; i++)
      send(1'b1, rows[i]);
    check_bit("req_ready when full", 1'b0, req_ready);
    check_bit("init_done early", 1'b0, init_done);
    req_valid = 1'b0;
    for (i = 0; i < 3000 && init_done !== 1'b1; i++)
      @(negedge sys_clk);
    if (i == 3000)
      timed_out("init_done");
    check_cnt("wake refreshes", WAKE_CYCLES, refresh_count);
    for (i = 0; i < 8; i++)
      send(1'b0, rows[i]);
    req_valid = 1'b0;
    wait_reads(8);
    for (i = 0; i < 8; i++)
      check_data("read word", rows[i].data, got[i]);
    // Overwrite then read back to back
    send(1'b1, '{rows[2].addr, 4'hE});
    send(1'b0, rows[2]);
    req_valid = 1'b0;
    wait_reads(9);
    check_data("read after overwrite", 4'hE, got[8]);
    // Refresh timer period is fixed by the controller
    rc = refresh_count;
    repeat (1700) @(negedge sys_clk);
    check_bit("periodic refresh", 1'b1, refresh_count > rc);
    send(1'b0, rows[0]);
    req_valid = 1'b0;
    wait_reads(10);
    check_data("read after refresh", rows[0].data, got[9]);
    check_cnt("strobe faults", 0, fault_count);
    check_cnt("data pin clash", 0, clash);
    // Second reset in mid-run
    reset = 1'b1;
    repeat (2) @(negedge sys_clk);
    check_bit("init_done after reset", 1'b0, init_done);
    check_bit("cas_n after reset", 1'b1, cas_n);
    reset = 1'b0;
    print_verdict();
  end
endmodule
// dram_host_tb
